// ==== design/gpc_port.sv ====
// general purpose pin port with external interrupt edge detection, APB slave
//
// Contract
// (RULE_01) eight pins, bit x controls pin x
// (RULE_02) input mode reads the pin level
// (RULE_03) input-mode latch write leaves pin alone
// (RULE_04) software avoids bit set/clear on latch
// (RULE_05) input option bit selects pull-up
// (RULE_06) input option bit enables pin interrupt
// (RULE_07) per-vector rising or falling sensitivity
// (RULE_08) pins on one vector are ANDed
// (RULE_09) vector fetch clears pending latch
// (RULE_10) sensitivity change clears pending latch
// (RULE_11) disabled pin feeds one to detector
// (RULE_12) software safe enable sequence
// (RULE_13) software safe disable sequence
// (RULE_14) output mode drives latch, reads latch
// (RULE_15) output option selects push-pull/open-drain
// (RULE_16) alternate output overrides direction/option
// (RULE_17) floating input before alternate input
// (RULE_18) input with alt output reads alt output
// (RULE_19) output with alt input sees latch
// (RULE_20) floating input before analog use
// (RULE_21) pin inputs pass two-stage synchroniser
`timescale 1ns/10ps
`include "gpc_defines.svh"
module gpc_port import gpc_pkg::*; #(
   parameter int NPINS = 8,
   parameter int NVEC = 4
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pins
   input wire logic [NPINS-1:0] pin_i,
   output logic [NPINS-1:0] pin_o,
   output logic [NPINS-1:0] pin_oe_o,
   output logic [NPINS-1:0] pin_pullup_o,
   // peripheral alternate functions
   input wire logic [NPINS-1:0] alt_out_en_i,
   input wire logic [NPINS-1:0] alt_out_i,
   input wire logic [NPINS-1:0] alt_in_en_i,
   output logic [NPINS-1:0] alt_in_o,
   // interrupt vectors
   input wire logic [NVEC-1:0] vec_fetch_i,
   output logic [NVEC-1:0] irq_req_o
);
   typedef struct packed {
      logic [NPINS-1:0] latch;
      logic [NPINS-1:0] dir;
      logic [NPINS-1:0] opt;
      logic [NVEC-1:0] sense;
      logic [NVEC-1:0] pend;
      logic [NVEC-1:0] det_prev;
      logic [NPINS*2-1:0] group;
      logic [31:0] rdata;
   } gpc_state_t;

   gpc_state_t s_q;
   gpc_state_t s_d;
   logic [NPINS-1:0] pin_sync;
   logic [NPINS-1:0] det_in;
   logic [NVEC-1:0] vec_level;
   logic [NVEC-1:0] vec_event;
   logic [NPINS-1:0] data_view;
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   gpc_sync #(
      .WIDTH(NPINS)
   ) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pin_i),
      .sync_o(pin_sync) // RULE_21
   );

   // pad control per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         always_comb begin
            if (alt_out_en_i[gi]) begin
               pin_oe_o[gi] = 1'b1; // RULE_16
               pin_o[gi] = alt_out_i[gi];
               pin_pullup_o[gi] = 1'b0;
            end else if (s_q.dir[gi]) begin
               // open drain only drives the low level
               pin_oe_o[gi] = s_q.opt[gi] | ~s_q.latch[gi]; // RULE_15
               pin_o[gi] = s_q.latch[gi]; // RULE_14
               pin_pullup_o[gi] = 1'b0;
            end else begin
               pin_oe_o[gi] = 1'b0; // RULE_03
               pin_o[gi] = 1'b0;
               pin_pullup_o[gi] = s_q.opt[gi]; // RULE_05
            end
            if (!s_q.dir[gi] && alt_out_en_i[gi]) begin
               data_view[gi] = alt_out_i[gi]; // RULE_18
            end else if (s_q.dir[gi]) begin
               data_view[gi] = s_q.latch[gi]; // RULE_14
            end else begin
               data_view[gi] = pin_sync[gi]; // RULE_02
            end
            // a peripheral whose input is switched off sees a steady low
            alt_in_o[gi] = alt_in_en_i[gi] &
               (s_q.dir[gi] ? s_q.latch[gi] : pin_sync[gi]); // RULE_19
            // disabled or output pins present a high level to the detector
            det_in[gi] = (!s_q.dir[gi] && s_q.opt[gi]) ? pin_sync[gi] : 1'b1; // RULE_11
         end
      end
   endgenerate

   // vector level: AND of its member pins, so a low pin masks the rest
   always_comb begin
      vec_level = '1;
      for (int p = 0; p < NPINS; p++) begin
         vec_level[s_q.group[p*2 +: 2]] = vec_level[s_q.group[p*2 +: 2]] & det_in[p]; // RULE_08
      end
   end

   generate
      for (gi = 0; gi < NVEC; gi++) begin : g_vec
         assign vec_event[gi] = (s_q.sense[gi] == `GPC_SENSE_RISE) ?
            (vec_level[gi] & ~s_q.det_prev[gi]) :
            (~vec_level[gi] & s_q.det_prev[gi]); // RULE_07
      end
   endgenerate

   assign addr_ok = (paddr_i == `GPC_OFF_DATA) || (paddr_i == `GPC_OFF_DIR) ||
      (paddr_i == `GPC_OFF_OPT) || (paddr_i == `GPC_OFF_SENSE) ||
      (paddr_i == `GPC_OFF_PEND) || (paddr_i == `GPC_OFF_ACK) ||
      (paddr_i == `GPC_OFF_GROUP);
   assign wr_en = psel_i & penable_i & pwrite_i & addr_ok;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;

   always_comb begin
      logic [NVEC-1:0] clr;
      clr = vec_fetch_i; // RULE_09
      s_d = s_q;
      s_d.det_prev = vec_level;
      if (wr_en) begin
         unique case (paddr_i)
            `GPC_OFF_DATA: s_d.latch = pwdata_i[NPINS-1:0]; // RULE_03
            `GPC_OFF_DIR: s_d.dir = pwdata_i[NPINS-1:0];
            `GPC_OFF_OPT: s_d.opt = pwdata_i[NPINS-1:0]; // RULE_06
            `GPC_OFF_SENSE: begin
               s_d.sense = pwdata_i[NVEC-1:0];
               clr = clr | (s_q.sense ^ pwdata_i[NVEC-1:0]); // RULE_10
            end
            `GPC_OFF_ACK: clr = clr | pwdata_i[NVEC-1:0];
            `GPC_OFF_GROUP: s_d.group = pwdata_i[NPINS*2-1:0];
            default: ;
         endcase
      end
      // a new edge in the clearing cycle survives
      s_d.pend = (s_q.pend & ~clr) | vec_event; // RULE_06
      if (rd_en) begin
         s_d.rdata = '0;
         if (paddr_i == `GPC_OFF_DATA) s_d.rdata[NPINS-1:0] = data_view;
         if (paddr_i == `GPC_OFF_DIR) s_d.rdata[NPINS-1:0] = s_q.dir;
         if (paddr_i == `GPC_OFF_OPT) s_d.rdata[NPINS-1:0] = s_q.opt;
         if (paddr_i == `GPC_OFF_SENSE) s_d.rdata[NVEC-1:0] = s_q.sense;
         if (paddr_i == `GPC_OFF_PEND) s_d.rdata[NVEC-1:0] = s_q.pend;
         if (paddr_i == `GPC_OFF_GROUP) s_d.rdata[NPINS*2-1:0] = s_q.group;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q.latch <= `GPC_RST_DATA;
         s_q.dir <= `GPC_RST_DIR; // RULE_01
         s_q.opt <= `GPC_RST_OPT;
         s_q.sense <= `GPC_RST_SENSE;
         s_q.pend <= '0;
         s_q.det_prev <= '1;
         s_q.group <= '0;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.rdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign irq_req_o = s_q.pend;
endmodule

// ==== shared/gpc_defines.svh ====
// register offsets, reset values and sense encodings for the pin control port
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH
`define GPC_OFF_DATA 12'h000
`define GPC_OFF_DIR 12'h004
`define GPC_OFF_OPT 12'h008
`define GPC_OFF_SENSE 12'h00C
`define GPC_OFF_PEND 12'h010
`define GPC_OFF_ACK 12'h014
`define GPC_OFF_GROUP 12'h018
`define GPC_RST_DATA 8'hFF
`define GPC_RST_DIR 8'h00
`define GPC_RST_OPT 8'h00
`define GPC_RST_SENSE 4'h0
`define GPC_SENSE_RISE 1'b1
`define GPC_SENSE_FALL 1'b0
`endif

// ==== shared/gpc_pkg.sv ====
// types for the pin control port
package gpc_pkg;
   typedef logic [7:0] gpc_byte_t;
   typedef logic [3:0] gpc_vec_t;
endpackage

// ==== design/gpc_sync.sv ====
// two-stage synchroniser, one per pin
`timescale 1ns/10ps
module gpc_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } gpc_sync_state_t;
   gpc_sync_state_t s_q;
   gpc_sync_state_t s_d;
   always_comb begin
      s_d.meta = async_i;
      s_d.stable = s_q.meta;
   end
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign sync_o = s_q.stable;
endmodule

// ==== tb/gpc_port_properties.sv ====
// assertions on the pin control port
`timescale 1ns/10ps
module gpc_port_properties import gpc_pkg::*; #(parameter int NPINS = 8, parameter int NVEC = 4) (
   // apb
   input wire logic clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
   input wire logic [11:0] paddr_i,
   // pins and vectors
   input wire logic [NPINS-1:0] pin_i, pin_o, pin_oe_o, pin_pullup_o, alt_out_en_i, alt_out_i,
   input wire logic [NVEC-1:0] vec_fetch_i, irq_req_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire acc = psel_i && penable_i;
   wire wr = acc && pwrite_i;
   chk_ready_high: assert property (pready_o) else $error("ready low");
   chk_err_map: assert property (acc && paddr_i[1:0] == 0 |-> pslverr_o == (paddr_i > 12'h018))
      else $error("slverr");
   chk_alt_take: assert property ((((pin_oe_o ^ alt_out_en_i) | (pin_o ^ alt_out_i))
      & alt_out_en_i) == '0) else $error("alt drive");
   chk_pull_input: assert property ((pin_pullup_o & pin_oe_o & ~alt_out_en_i) == '0)
      else $error("pullup on output");
   chk_reset_idle: assert property ($fell(sys_rst_i) |-> !(pin_oe_o & ~alt_out_en_i) && !irq_req_o)
      else $error("reset state");
   chk_fetch_clear: assert property (vec_fetch_i != 0 && !$past(wr)
      && $past(pin_i, 2) == $past(pin_i, 3) |=> !(irq_req_o & $past(vec_fetch_i)))
      else $error("fetch");
   chk_irq_fall: assert property (|($past(irq_req_o) & ~irq_req_o) |-> $past(wr || vec_fetch_i != 0))
      else $error("irq lost");
   chk_irq_rise: assert property (|(irq_req_o & ~$past(irq_req_o))
      |-> $past(wr, 2) || $past(pin_i, 3) != $past(pin_i, 4)) else $error("irq cause");
   cover property (irq_req_o != 0);
   cover property (|(vec_fetch_i & irq_req_o));
   cover property (acc && pslverr_o);
endmodule
bind gpc_port gpc_port_properties #(.NPINS(NPINS), .NVEC(NVEC)) u_props (.clock_i(clock_i),
   .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .paddr_i(paddr_i), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
   .alt_out_en_i(alt_out_en_i), .alt_out_i(alt_out_i), .vec_fetch_i(vec_fetch_i),
   .irq_req_o(irq_req_o));

// ==== tb/gpc_pin_model.sv ====
// far side of the pins: outside drivers meet the port drivers
`timescale 1ns/10ps
module gpc_pin_model (
   // port drive and outside level
   input wire logic [7:0] pin_o, pin_oe_o, ext_v,
   output logic [7:0] pin_i
);
   // released open-drain bits show the outside level, never the latch
   assign pin_i = pin_oe_o & pin_o | ~pin_oe_o & ext_v;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the pin control port
`timescale 1ns/10ps
module testbench;
   import gpc_pkg::*;
   logic clock_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, q;
   gpc_byte_t pin_i, pin_o, pin_oe_o, pin_pullup_o, alt_in_o, r, d, o, ext_v = '0;
   gpc_byte_t alt_out_en_i = '0, alt_out_i = '0, alt_in_en_i = 8'hFF;
   gpc_vec_t vec_fetch_i = '0, irq_req_o;
   int error_cnt = 0, check_count = 0, cyc = 0;
   gpc_port DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o),
      .alt_out_en_i(alt_out_en_i), .alt_out_i(alt_out_i), .alt_in_en_i(alt_in_en_i),
      .alt_in_o(alt_in_o), .vec_fetch_i(vec_fetch_i), .irq_req_o(irq_req_o));
   gpc_pin_model PINS (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_v(ext_v), .pin_i(pin_i));
   initial forever #20 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end
   function automatic gpc_byte_t mix(gpc_byte_t s, a, b);
      return s & a | ~s & b;
   endfunction
   task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
      @(posedge clock_i) {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, v};
      @(posedge clock_i) penable_i <= 1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      q = prdata_o;
      {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic chk(string s, logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e, string s);
      apb(0, a, 0);
      chk(s, e, q);
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clock_i);
      @(negedge clock_i);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      void'($urandom(98));
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 0;
      apb(1, 12'h01C, 32'hFFFF_FFFF);
      for (int i = 1; i < 8; i++) if (i != 6) rd(12'(i * 4), 0, "reset");
      repeat (3) begin
         {r, d, o} = 24'($urandom);
         @(posedge clock_i) {ext_v, alt_in_en_i} <= {r, ~o};
         apb(1, 12'h004, 0);
         apb(1, 12'h008, 0);
         apb(1, 12'h000, d);
         wt(3);
         chk("ain in", r & ~o, alt_in_o);
         rd(12'h000, r, "in");
         apb(1, 12'h008, o);
         apb(1, 12'h004, 8'hFF);
         wt(0);
         chk("oe", mix(o, 8'hFF, ~d), pin_oe_o);
         chk("drv", d, pin_o);
         chk("ain", d & ~o, alt_in_o);
         rd(12'h000, d, "out");
         apb(1, 12'h004, 0);
         @(posedge clock_i) {alt_out_en_i, alt_out_i} <= {o, d};
         wt(3);
         rd(12'h000, mix(o, d, r), "alt");
         @(posedge clock_i) alt_out_en_i <= 0;
      end
      apb(1, 12'h008, 0);
      apb(1, 12'h018, 0);
      @(posedge clock_i) ext_v <= 0;
      wt(3);
      apb(1, 12'h014, 4'hF);
      // falling sense with the pin low: enabling raises a request
      apb(1, 12'h008, 1);
      wt(2);
      chk("spur", 1, irq_req_o);
      chk("pull", 1, pin_pullup_o);
      @(posedge clock_i) vec_fetch_i <= 1;
      @(posedge clock_i) vec_fetch_i <= 0;
      wt(0);
      chk("fetch", 0, irq_req_o);
      apb(1, 12'h00C, 1);
      @(posedge clock_i) ext_v <= 1;
      wt(4);
      chk("rise", 1, irq_req_o);
      apb(1, 12'h00C, 0);
      wt(0);
      chk("sense", 0, irq_req_o);
      @(posedge clock_i) ext_v <= 3;
      apb(1, 12'h008, 3);
      @(posedge clock_i) ext_v <= 1;
      wt(4);
      chk("and", 1, irq_req_o);
      apb(1, 12'h014, 1);
      @(posedge clock_i) ext_v <= 0;
      wt(4);
      chk("mask", 0, irq_req_o);
      // safe disable then safe enable with the pin held low
      apb(1, 12'h008, 0);
      apb(1, 12'h00C, 1);
      wt(4);
      chk("safe off", 0, irq_req_o);
      apb(1, 12'h008, 1);
      apb(1, 12'h00C, 0);
      wt(4);
      chk("safe on", 0, irq_req_o);
      // rising sense with the pin low: disabling raises a request
      apb(1, 12'h00C, 1);
      apb(1, 12'h008, 0);
      wt(2);
      chk("spur off", 1, irq_req_o);
      print_verdict();
   end
endmodule
